// >>> bdm_defines.svh
// register offsets, field positions, reset values and counts of the block mover
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH

// register byte offsets
`define BDM_OFF_CMD       16'h1600
`define BDM_OFF_SRC       16'h1680
`define BDM_OFF_DST       16'h16c0
`define BDM_OFF_RANGE0    16'h1e00
`define BDM_OFF_RANGE1    16'h1e40

// command register fields
`define BDM_CMD_DONE      31
`define BDM_CMD_BUSY      30
`define BDM_CMD_INIT      16
`define BDM_CMD_INTLV     14
`define BDM_CMD_F4        13
`define BDM_CMD_F3        12
`define BDM_CMD_VALID     11
`define BDM_CMD_OP_HI     9
`define BDM_CMD_OP_LO     8
`define BDM_CMD_SIZE_HI   4

// range register fields
`define BDM_RNG_VALID     31
`define BDM_RNG_BASE_HI   26
`define BDM_RNG_BASE_LO   8
`define BDM_RNG_ILV       4
`define BDM_RNG_EXT_HI    3

// reset values
`define BDM_RESET_WORD    32'h0000_0000

// block of 64 bytes; per size bit 8, 16, 32, 64 or 128 blocks
`define BDM_BLK_SHIFT     6
`define BDM_BLKS_BASE     8'h08

// bus answers
`define BDM_RESP_OKAY     2'h0
`define BDM_RESP_SLVERR   2'h2

`endif

// >>> bdm_mover.sv
// block data mover: register slave on axi4-lite and system bus sequencer
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "bdm_defines.svh"

// Functional notes
// - done sets at finish, initiator one clears
// - while done, only initiator writes command
// - done reads zero for non-initiator
// - busy sets on valid write, clears at finish
// - busy reads zero for non-initiator
// - initiator bit: one second cpu, zero first
// - interleave bit steers address bit three/four
// - force bits drive address bits four, three
// - command valid bit starts, clears on read
// - opcode zero writes zeros from source
// - opcode one reads source blocks shared
// - opcode two copies source to destination
// - opcode three rewrites source onto itself
// - exactly one one-hot size bit selects length
// - addresses hold bits 38:9, 512-byte aligned
// - range used only while its valid set
// - range base bits 38:20, extent aligned
// - range interleave splits on address bit six
// - extent code gives power-of-two region size
module bdm_mover #(
  parameter int DATA_W = 512
) (
  input  wire logic                REF_CLK,
  input  wire logic                RST,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [15:0]         AWADDR,
  input  wire logic                AWCPU,
  input  wire logic                WVALID,
  output logic                     WREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  output logic                     BVALID,
  input  wire logic                BREADY,
  output logic [1:0]               BRESP,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  input  wire logic [15:0]         ARADDR,
  input  wire logic                ARCPU,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP,
  output logic                     SB_VALID,
  output bdm_pkg::bdm_sbreq_t      SB_INFO,
  output logic [DATA_W-1:0]        SB_WDATA,
  input  wire logic                SB_ACK,
  input  wire logic [DATA_W-1:0]   SB_RDATA
);

  // write channel holding registers
  logic                  aw_held_ff;
  logic [15:0]           aw_addr_ff;
  logic                  aw_cpu_ff;
  logic                  w_held_ff;
  logic [31:0]           w_data_ff;
  logic [3:0]            w_strb_ff;
  logic                  aw_take;
  logic                  w_take;
  logic                  wr_fire;
  logic                  rd_fire;
  logic                  nxt_aw_held;
  logic                  nxt_w_held;
  logic                  nxt_rvalid;

  // register state
  bdm_pkg::bdm_ctl_t     ctl_ff;
  logic                  done_ff;
  logic                  busy_ff;
  logic                  init_ff;
  logic                  valid_ff;
  logic [29:0]           src_ff;
  logic [29:0]           dst_ff;
  bdm_pkg::bdm_range_t   rng_ff [2];

  // mover state
  bdm_pkg::bdm_state_t   state_ff;
  bdm_pkg::bdm_ctl_t     run_ff;
  logic [39:0]           run_src_ff;
  logic [39:0]           run_dst_ff;
  logic [7:0]            off_ff;
  logic [7:0]            last_ff;
  logic                  phase_wr_ff;
  logic [DATA_W-1:0]     buf_ff;

  // decoded and combinational terms
  logic [15:0]           wa;
  logic [15:0]           ra;
  logic                  wsel_cmd;
  logic                  wsel_src;
  logic                  wsel_dst;
  logic [1:0]            wsel_rng;
  logic                  rsel_cmd;
  logic [31:0]           cmd_view;
  logic [31:0]           wd_cmd;
  logic                  wr_cmd;
  logic                  cmd_write_ok;
  logic                  start;
  logic                  size_ok;
  logic [7:0]            blocks;
  logic                  finish;
  logic                  beat_done;
  logic [39:0]           cur_base;
  logic [39:0]           cur_addr;
  logic [1:0]            hit;
  logic                  bit4;
  logic                  bit3;
  logic [31:0]           rd_word;
  logic                  rd_ok;
  logic                  own;
  logic [31:0]           wd_src;
  logic [31:0]           wd_dst;
  logic [31:0]           wd_rng [2];

  // byte-lane merge of a write into the present word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] rng_word(input bdm_pkg::bdm_range_t r);
    return {r.valid, 4'h0, r.base, 3'h0, r.ilv, r.extent};
  endfunction

  // region match: base compare above the extent, interleave on bit six
  function automatic logic rng_hit(input bdm_pkg::bdm_range_t r,
                                   input logic [39:0] a,
                                   input logic odd);
    logic [18:0] mask;
    mask = ~((19'h00001 << r.extent) - 19'h00001);
    return r.valid && !a[39]
           && (((a[38:20] ^ r.base) & mask) == 19'h00000)
           && (!r.ilv || (a[6] == odd));
  endfunction

  // handshakes: address and data are taken in either order
  assign aw_take     = AWVALID & AWREADY;
  assign w_take      = WVALID & WREADY;
  assign wr_fire     = aw_held_ff & w_held_ff & ~BVALID;
  assign rd_fire     = ARVALID & ARREADY;
  assign nxt_aw_held = aw_take | (aw_held_ff & ~wr_fire);
  assign nxt_w_held  = w_take | (w_held_ff & ~wr_fire);
  assign nxt_rvalid  = rd_fire | (RVALID & ~RREADY);

  // address decode on word-aligned offsets
  assign wa       = {aw_addr_ff[15:2], 2'b00};
  assign ra       = {ARADDR[15:2], 2'b00};
  assign wsel_cmd = (wa == `BDM_OFF_CMD);
  assign wsel_src = (wa == `BDM_OFF_SRC);
  assign wsel_dst = (wa == `BDM_OFF_DST);
  assign wsel_rng = {wa == `BDM_OFF_RANGE1, wa == `BDM_OFF_RANGE0};
  assign rsel_cmd = (ra == `BDM_OFF_CMD);

  // stored command view, used for byte-lane merging of writes
  assign cmd_view = {done_ff, busy_ff, 13'h0000, init_ff, 1'b0,
                     ctl_ff.intlv, ctl_ff.force4, ctl_ff.force3, valid_ff,
                     1'b0, ctl_ff.op, 3'h0, ctl_ff.size};
  assign wd_cmd   = merge(cmd_view, w_data_ff, w_strb_ff);
  assign wr_cmd   = wr_fire & wsel_cmd;

  // merged words for the address and range registers
  assign wd_src    = merge({2'b00, src_ff}, w_data_ff, w_strb_ff);
  assign wd_dst    = merge({2'b00, dst_ff}, w_data_ff, w_strb_ff);
  assign wd_rng[0] = merge(rng_word(rng_ff[0]), w_data_ff, w_strb_ff);
  assign wd_rng[1] = merge(rng_word(rng_ff[1]), w_data_ff, w_strb_ff);

  // a busy mover or a foreign cpu during done leaves the command alone
  assign cmd_write_ok = wr_cmd & ~busy_ff
                        & ~(done_ff & (aw_cpu_ff != init_ff));
  assign start        = cmd_write_ok & wd_cmd[`BDM_CMD_VALID];

  // length from the one-hot size field; anything else moves nothing
  always_comb begin
    size_ok = 1'b0;
    blocks  = 8'h00;
    unique case (wd_cmd[`BDM_CMD_SIZE_HI:0])
      5'h01: begin size_ok = 1'b1; blocks = `BDM_BLKS_BASE; end
      5'h02: begin size_ok = 1'b1; blocks = `BDM_BLKS_BASE << 1; end
      5'h04: begin size_ok = 1'b1; blocks = `BDM_BLKS_BASE << 2; end
      5'h08: begin size_ok = 1'b1; blocks = `BDM_BLKS_BASE << 3; end
      5'h10: begin size_ok = 1'b1; blocks = `BDM_BLKS_BASE << 4; end
      default: begin size_ok = 1'b0; blocks = 8'h00; end
    endcase
  end

  assign beat_done = (state_ff == bdm_pkg::BDM_ST_WAIT) & SB_ACK;
  assign finish    = (beat_done & (off_ff == last_ff)
                      & (phase_wr_ff | run_ff.op == bdm_pkg::BDM_OP_SHARE))
                     | (start & ~size_ok);

  // address of the current beat; copy writes go to the destination
  assign cur_base = (phase_wr_ff && run_ff.op == bdm_pkg::BDM_OP_COPY)
                    ? run_dst_ff : run_src_ff;
  assign cur_addr = cur_base + {26'h0000000, off_ff, 6'h00};

  // channel steering of address bits four and three
  always_comb begin
    hit[0] = rng_hit(rng_ff[0], cur_addr, 1'b0);
    hit[1] = rng_hit(rng_ff[1], cur_addr, 1'b1);
    if (run_ff.force4 | run_ff.force3) begin
      bit4 = run_ff.force4;
      bit3 = run_ff.force3;
    end else begin
      bit3 = (run_ff.intlv & cur_addr[6]) | hit[0];
      bit4 = (~run_ff.intlv & ~cur_addr[6]) | hit[1];
    end
  end

  // write address channel; ready drops while an address is held
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= 16'h0000;
      aw_cpu_ff  <= 1'b0;
      AWREADY    <= 1'b0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      AWREADY    <= ~nxt_aw_held;
      if (aw_take) begin
        aw_addr_ff <= AWADDR;
        aw_cpu_ff  <= AWCPU;
      end
    end
  end

  // write data channel
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      w_held_ff <= 1'b0;
      w_data_ff <= `BDM_RESET_WORD;
      w_strb_ff <= 4'h0;
      WREADY    <= 1'b0;
    end else begin
      w_held_ff <= nxt_w_held;
      WREADY    <= ~nxt_w_held;
      if (w_take) begin
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
      end
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      BVALID <= 1'b0;
      BRESP  <= `BDM_RESP_OKAY;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      BRESP  <= (wsel_cmd | wsel_src | wsel_dst | (|wsel_rng))
                ? `BDM_RESP_OKAY : `BDM_RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // read view; flags of a foreign cpu read as zero
  always_comb begin
    own     = (ARCPU == init_ff);
    rd_ok   = 1'b1;
    rd_word = `BDM_RESET_WORD;
    if (ra == `BDM_OFF_CMD) begin
      rd_word = cmd_view;
      rd_word[`BDM_CMD_DONE] = done_ff & own;
      rd_word[`BDM_CMD_BUSY] = busy_ff & own;
    end else if (ra == `BDM_OFF_RANGE0) begin
      rd_word = rng_word(rng_ff[0]);
    end else if (ra == `BDM_OFF_RANGE1) begin
      rd_word = rng_word(rng_ff[1]);
    end else if (ra != `BDM_OFF_SRC && ra != `BDM_OFF_DST) begin
      rd_ok = 1'b0;                     // address registers are write-only
    end
  end

  // read channel: one read at a time, answer one cycle after the take
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= `BDM_RESET_WORD;
      RRESP   <= `BDM_RESP_OKAY;
    end else begin
      ARREADY <= ~nxt_rvalid;
      RVALID  <= nxt_rvalid;
      if (rd_fire) begin
        RDATA <= rd_word;
        RRESP <= rd_ok ? `BDM_RESP_OKAY : `BDM_RESP_SLVERR;
      end
    end
  end

  // command fields and the initiator record
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctl_ff  <= '0;
      init_ff <= 1'b0;
    end else if (cmd_write_ok) begin
      ctl_ff.intlv  <= wd_cmd[`BDM_CMD_INTLV];
      ctl_ff.force4 <= wd_cmd[`BDM_CMD_F4];
      ctl_ff.force3 <= wd_cmd[`BDM_CMD_F3];
      ctl_ff.op     <= bdm_pkg::bdm_op_t'(wd_cmd[`BDM_CMD_OP_HI:`BDM_CMD_OP_LO]);
      ctl_ff.size   <= wd_cmd[`BDM_CMD_SIZE_HI:0];
      if (start) begin
        init_ff <= aw_cpu_ff;
      end
    end
  end

  // valid bit: a read of the command clears it, a start sets it
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      valid_ff <= 1'b0;
    end else if (start) begin
      valid_ff <= 1'b1;
    end else if (rd_fire & rsel_cmd) begin
      valid_ff <= 1'b0;
    end
  end

  // done: set at finish wins over the initiator's one-to-clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      done_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= 1'b1;
    end else if (wr_cmd & (aw_cpu_ff == init_ff) & w_strb_ff[3]
                 & w_data_ff[`BDM_CMD_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  // busy: set by a valid command, cleared by its completion
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      busy_ff <= 1'b0;
    end else if (finish) begin
      busy_ff <= 1'b0;
    end else if (start) begin
      busy_ff <= 1'b1;
    end
  end

  // address registers; reserved top bits are dropped
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      src_ff <= 30'h00000000;
      dst_ff <= 30'h00000000;
    end else if (wr_fire) begin
      if (wsel_src) begin
        src_ff <= wd_src[29:0];
      end
      if (wsel_dst) begin
        dst_ff <= wd_dst[29:0];
      end
    end
  end

  // range registers; reserved fields read back as zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rng_ff[0] <= '0;
      rng_ff[1] <= '0;
    end else if (wr_fire) begin
      for (int i = 0; i < 2; i++) begin
        if (wsel_rng[i]) begin
          rng_ff[i] <= bdm_pkg::bdm_range_t'({
            wd_rng[i][31], wd_rng[i][26:8], wd_rng[i][4:0]});
        end
      end
    end
  end

  // sequencer: one block per beat, read then write where the op needs it
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_ff    <= bdm_pkg::BDM_ST_IDLE;
      run_ff      <= '0;
      run_src_ff  <= 40'h0000000000;
      run_dst_ff  <= 40'h0000000000;
      off_ff      <= 8'h00;
      last_ff     <= 8'h00;
      phase_wr_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        bdm_pkg::BDM_ST_IDLE: begin
          if (start & size_ok) begin
            run_ff.intlv  <= wd_cmd[`BDM_CMD_INTLV];
            run_ff.force4 <= wd_cmd[`BDM_CMD_F4];
            run_ff.force3 <= wd_cmd[`BDM_CMD_F3];
            run_ff.op     <= bdm_pkg::bdm_op_t'(
                               wd_cmd[`BDM_CMD_OP_HI:`BDM_CMD_OP_LO]);
            run_ff.size   <= wd_cmd[`BDM_CMD_SIZE_HI:0];
            run_src_ff    <= {1'b0, src_ff, 9'h000};
            run_dst_ff    <= {1'b0, dst_ff, 9'h000};
            off_ff        <= 8'h00;
            last_ff       <= blocks - 8'h01;
            // zero fill starts with a write, the others with a read
            phase_wr_ff   <= (wd_cmd[`BDM_CMD_OP_HI:`BDM_CMD_OP_LO] ==
                              2'h0);
            state_ff      <= bdm_pkg::BDM_ST_ISSUE;
          end
        end
        bdm_pkg::BDM_ST_ISSUE: begin
          state_ff <= bdm_pkg::BDM_ST_WAIT;
        end
        bdm_pkg::BDM_ST_WAIT: begin
          if (SB_ACK) begin
            if (!phase_wr_ff && run_ff.op != bdm_pkg::BDM_OP_SHARE) begin
              phase_wr_ff <= 1'b1;
              state_ff    <= bdm_pkg::BDM_ST_ISSUE;
            end else if (off_ff == last_ff) begin
              state_ff    <= bdm_pkg::BDM_ST_IDLE;
            end else begin
              off_ff      <= off_ff + 8'h01;
              phase_wr_ff <= (run_ff.op == bdm_pkg::BDM_OP_ZERO);
              state_ff    <= bdm_pkg::BDM_ST_ISSUE;
            end
          end
        end
      endcase
    end
  end

  // read data kept for the following write of a copy
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      buf_ff <= '0;
    end else if (beat_done & ~phase_wr_ff) begin
      buf_ff <= SB_RDATA;
    end
  end

  // system bus request stands from issue until acknowledged
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      SB_VALID <= 1'b0;
      SB_INFO  <= '0;
      SB_WDATA <= '0;
    end else if (state_ff == bdm_pkg::BDM_ST_ISSUE) begin
      SB_VALID     <= 1'b1;
      SB_INFO.cmd  <= phase_wr_ff ? bdm_pkg::BDM_SB_WRITE
                                  : bdm_pkg::BDM_SB_READ_SHARED;
      SB_INFO.addr <= {cur_addr[39:5], bit4, bit3, cur_addr[2:0]};
      // zero fill sends zeros, the copies send what was read
      SB_WDATA     <= (run_ff.op == bdm_pkg::BDM_OP_ZERO)
                      ? '0 : buf_ff;
    end else if (SB_ACK) begin
      SB_VALID <= 1'b0;
    end
  end

endmodule

// >>> bdm_mover_asserts.sv
// concurrent port checks for the block mover
module bdm_mover_asserts #(
  parameter int DATA_W = 512
) (
  input wire logic                REF_CLK,
  input wire logic                RST,
  input wire logic                AWVALID,
  input wire logic                AWREADY,
  input wire logic                WVALID,
  input wire logic                WREADY,
  input wire logic                BVALID,
  input wire logic                BREADY,
  input wire logic [1:0]          BRESP,
  input wire logic                ARVALID,
  input wire logic                ARREADY,
  input wire logic                RVALID,
  input wire logic                RREADY,
  input wire logic [31:0]         RDATA,
  input wire logic                SB_VALID,
  input wire bdm_pkg::bdm_sbreq_t SB_INFO,
  input wire logic [DATA_W-1:0]   SB_WDATA,
  input wire logic                SB_ACK,
  input wire logic [DATA_W-1:0]   SB_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // a read beat taken on the system bus
  logic rd_ack;
  assign rd_ack = SB_VALID && SB_ACK && !SB_INFO.cmd;

  sequence s_both_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence s_read_then_write;
    rd_ack ##2 (SB_VALID && SB_INFO.cmd);
  endsequence

  a_write_answer: assert property (
    s_both_taken |-> ##[1:3] BVALID) else $error("write not answered");
  a_bvalid_stand: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_read_answer: assert property (
    ARVALID && ARREADY |-> ##[1:2] RVALID) else $error("read not answered");
  a_rvalid_stand: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_sb_hold: assert property (
    SB_VALID && !SB_ACK |=> SB_VALID && $stable(SB_INFO)
    && $stable(SB_WDATA)) else $error("bus request changed");
  a_sb_gap: assert property (
    SB_VALID && SB_ACK |=> !SB_VALID) else $error("request after ack");
  a_addr_align: assert property (
    SB_VALID |-> !SB_INFO.addr[39] && !SB_INFO.addr[5]
    && SB_INFO.addr[2:0] == 3'h0) else $error("bus address misaligned");
  a_copy_data: assert property (
    s_read_then_write |-> SB_WDATA == $past(SB_RDATA, 2))
    else $error("written data differs from read data");
  a_zero_data: assert property (
    $rose(SB_VALID) && SB_INFO.cmd && !$past(rd_ack, 2) |-> SB_WDATA == '0)
    else $error("fill write not zero");
endmodule

// >>> bdm_pkg.sv
// types shared by the block mover
package bdm_pkg;

  typedef enum logic [1:0] {
    BDM_OP_ZERO,
    BDM_OP_SHARE,
    BDM_OP_COPY,
    BDM_OP_SELF
  } bdm_op_t;

  typedef enum logic {
    BDM_SB_READ_SHARED,
    BDM_SB_WRITE
  } bdm_sbcmd_t;

  typedef enum logic [1:0] {
    BDM_ST_IDLE,
    BDM_ST_ISSUE,
    BDM_ST_WAIT
  } bdm_state_t;

  typedef struct packed {
    logic    intlv;
    logic    force4;
    logic    force3;
    bdm_op_t op;
    logic [4:0] size;
  } bdm_ctl_t;

  typedef struct packed {
    logic        valid;
    logic [18:0] base;
    logic        ilv;
    logic [3:0]  extent;
  } bdm_range_t;

  typedef struct packed {
    bdm_sbcmd_t  cmd;
    logic [39:0] addr;
  } bdm_sbreq_t;

endpackage

// >>> bdm_sysmem.sv
// system bus memory model facing the block mover
module bdm_sysmem #(
  parameter int DW = 512
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                req,
  input wire bdm_pkg::bdm_sbreq_t info,
  input wire logic [DW-1:0]       wdata,
  input wire logic [1:0]          lag,
  output logic                    ack,
  output logic [DW-1:0]           rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] mem [logic [33:0]];
  logic [1:0]    cnt;

  // answer after lag cycles; idle data toggles so it never looks held
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      cnt <= 2'h0;
      rdata <= '0;
    end else if (req && !ack && cnt != lag) begin
      cnt <= cnt + 2'h1;
    end else if (req && !ack) begin
      cnt <= 2'h0;
      ack <= 1'b1;
      if (info.cmd) mem[info.addr[39:6]] = wdata;
      else if (mem.exists(info.addr[39:6])) rdata <= mem[info.addr[39:6]];
      else rdata <= {(DW/32){info.addr[37:6]}}; // unwritten block pattern
    end
  end
endmodule

// >>> tb_block_data_mover.sv
// self-checking bench for the block mover
module tb_block_data_mover;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DW = 512;
  logic REF_CLK, RST, AWVALID, AWREADY, AWCPU, WVALID, WREADY, BVALID;
  logic BREADY, ARVALID, ARREADY, ARCPU, RVALID, RREADY, SB_VALID, SB_ACK;
  logic il, f4, f3, rng, cpu;
  logic [15:0]         AWADDR, ARADDR;
  logic [31:0]         WDATA, RDATA, rd, cw, rv, srcw, ci, lf;
  logic [3:0]          WSTRB;
  logic [1:0]          BRESP, RRESP, rr, op, lag;
  logic [4:0]          sz;
  logic [39:0]         sa, ma;
  logic [DW-1:0]       SB_WDATA, SB_RDATA;
  bdm_pkg::bdm_sbreq_t SB_INFO;
  int                  error_cnt, checks_done, n_rd, n_wr, b, n;

  bdm_mover #(.DATA_W(DW)) u_bdm_mover (.*);
  bdm_sysmem #(.DW(DW)) u_bdm_sysmem (.clk(REF_CLK), .rst(RST),
    .req(SB_VALID), .info(SB_INFO), .wdata(SB_WDATA), .lag(lag),
    .ack(SB_ACK), .rdata(SB_RDATA));

  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end

  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [DW-1:0] pat(logic [39:0] a);
    return {(DW/32){a[37:6]}};
  endfunction
  // force bits win; else interleave, then a valid range hit
  function automatic logic [1:0] exp_ch(logic a6);
    if (f4 || f3) return {f4, f3};
    return {(!il && !a6) || (rng && a6), (il && a6) || (rng && !a6)};
  endfunction

  task automatic chk(input logic [DW-1:0] g, input logic [DW-1:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tmo(input logic hit);
    if (hit) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  // write: both channels offered together, each released when taken
  task automatic axi_wr(input logic c, input logic [15:0] a,
                        input logic [31:0] d, output logic [1:0] r);
    int k;
    logic aw, w;
    @(posedge REF_CLK);
    {AWVALID, WVALID, BREADY} <= 3'h7;
    {AWCPU, AWADDR, WDATA} <= {c, a, d};
    {aw, w, k} = {2'h3, 32'h0};
    while ((aw || w) && k < 60) begin
      @(posedge REF_CLK);
      k++;
      // release by nonblocking so the slave still sees the taking edge
      if (aw && AWREADY) begin
        aw = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY) begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
    end
    do begin
      @(posedge REF_CLK);
      k++;
    end while (!BVALID && k < 60);
    r = BRESP;
    BREADY <= 1'b0;
    tmo(k >= 60);
  endtask
  task automatic axi_rd(input logic c, input logic [15:0] a,
                        output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge REF_CLK);
    {ARVALID, RREADY, ARCPU, ARADDR} <= {2'h3, c, a};
    k = 0;
    do begin
      @(posedge REF_CLK);
      k++;
    end while (!ARREADY && k < 60);
    ARVALID <= 1'b0;
    do begin
      @(posedge REF_CLK);
      k++;
    end while (!RVALID && k < 60);
    {d, r} = {RDATA, RRESP};
    RREADY <= 1'b0;
    tmo(k >= 60);
  endtask
  task automatic rdchk(input logic c, input logic [15:0] a,
                       input logic [31:0] e);
    axi_rd(c, a, rd, rr);
    chk(rd, e);
  endtask

  // count bus beats, check channel bits, vary the memory lag
  always @(posedge REF_CLK) begin
    if (!RST && SB_VALID && SB_ACK) begin
      if (SB_INFO.cmd) n_wr++;
      else n_rd++;
      chk(SB_INFO.addr[4:3], exp_ch(SB_INFO.addr[6]));
      lf = lfsr(lf);
      lag <= lf[1:0];
    end
  end

  initial begin
    {RST, AWVALID, AWCPU, WVALID, BREADY, ARVALID, ARCPU, RREADY} = 8'h80;
    {AWADDR, ARADDR, WDATA, WSTRB, lag} = {64'h0, 4'hf, 2'h0};
    {lf, error_cnt, checks_done, n_rd, n_wr} = {32'h5156, 128'h0};
    repeat (10) @(posedge REF_CLK);
    RST <= 1'b0;
    rdchk(1'b0, 16'h1600, 32'h0);
    axi_rd(1'b1, 16'h1704, rd, rr);
    chk({rr, rd}, {2'h2, 32'h0});
    axi_wr(1'b1, 16'h1704, 32'hffff_ffff, rr);
    chk(rr, 2'h2);
    for (int i = 0; i < 5; i++) begin
      lf = lfsr(lf);
      srcw = {2'h0, lf[29:0] & 30'h3fff_f80f};
      {cpu, sz, b, op} = {i[0], 5'h01 << i, 32'h8 << i,
                          (i == 4) ? 2'h2 : i[1:0]};
      {il, f4, f3, rng} = {i == 3, i == 0 || i == 2, i == 1 || i == 2, i == 4};
      ci = {15'h0, cpu, 16'h0};
      // both ranges alike, base covering the source, valid only at the end
      rv = {rng, 4'h0, srcw[29:11], 3'h0, 1'b1, 4'h0};
      axi_wr(1'b0, 16'h1e00, rv | 32'h7800_00e0, rr);
      axi_wr(1'b1, 16'h1e40, rv, rr);
      rdchk(1'b1, 16'h1e00, rv);
      axi_wr(cpu, 16'h1680, srcw, rr);
      axi_wr(cpu, 16'h16c0, srcw + 32'h10, rr);
      rdchk(cpu, 16'h16c0, 32'h0);
      {n_rd, n_wr} = 64'h0;
      cw = {17'h0, il, f4, f3, 1'b1, 1'b0, op, 3'h0, sz};
      axi_wr(cpu, 16'h1600, cw, rr);
      rdchk(cpu, 16'h1600, cw | ci | 32'h4000_0000);
      rdchk(!cpu, 16'h1600, cw & 32'h731f | ci);
      axi_wr(cpu, 16'h1600, 32'h0000_0a01, rr);
      rd = 32'h0;
      for (n = 0; n < 900 && !rd[31]; n++) axi_rd(cpu, 16'h1600, rd, rr);
      tmo(!rd[31]);
      chk(rd, cw & 32'h731f | ci | 32'h8000_0000);
      chk({n_rd, n_wr}, {op == 0 ? 0 : b, op == 1 ? 0 : b});
      rdchk(!cpu, 16'h1600, cw & 32'h731f | ci);
      axi_wr(!cpu, 16'h1600, 32'h8000_0000, rr);
      rdchk(cpu, 16'h1600, cw & 32'h731f | ci | 32'h8000_0000);
      axi_wr(cpu, 16'h1600, 32'h8000_0000, rr);
      rdchk(cpu, 16'h1600, ci);
      for (int k = 0; k < b && op != 1; k++) begin
        sa = {1'b0, srcw[29:0], 9'h0} + 40'(k * 64);
        ma = (op == 2) ? sa + 40'h2000 : sa;
        chk(u_bdm_sysmem.mem[ma[39:6]], op == 0 ? '0 : pat(sa));
      end
    end
    {n_rd, n_wr} = 64'h0;
    axi_wr(1'b0, 16'h1600, 32'h0000_0803, rr);
    rdchk(1'b0, 16'h1600, 32'h8000_0803);
    chk(n_rd + n_wr, 0);
    wrap_up();
  end
endmodule

bind bdm_mover bdm_mover_asserts #(.DATA_W(DATA_W)) u_chk (.*);
